/* i2c_host_model.sv */
// Two-wire bus host that configures the LED device
module i2c_host_model (
  input  wire logic clk,
  input  wire logic sdaOe,
  input  wire logic sdaOut,
  output      logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sdaDrv;
  // Open drain with pull-up: a released line reads high
  assign sda = sdaDrv & ~(sdaOe & ~sdaOut);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // Half period of four cycles keeps above the three-cycle minimum
  task automatic half();
    repeat (4) @(posedge clk);
  endtask : half
  task automatic start();
    sdaDrv <= 1'b1;
    scl <= 1'b1;
    half();
    sdaDrv <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask : start
  task automatic stop();
    sdaDrv <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sdaDrv <= 1'b1;
    half();
  endtask : stop
  // Data moves only while the clock is low, so no false start or stop
  task automatic bitx(input logic b, output logic r);
    sdaDrv <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
    half();
  endtask : bitx
  task automatic xfer(input logic [7:0] b, input logic ackIn, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r[i]);
    end
    bitx(ackIn, ack);
  endtask : xfer
endmodule : i2c_host_model

/* led_engine_pkg.sv */
// Shared constants and types of the LED pattern engine
package led_engine_pkg;
  localparam int unsigned CORE_HZ     = 40_000_000;
  localparam int unsigned ENG_HZ      = 32_768;
  localparam int unsigned PWM_LOW_HZ  = 256;
  localparam int unsigned PWM_HIGH_HZ = 558;
  localparam logic [10:0] TICK_CYCLES   = 11'(CORE_HZ / ENG_HZ);
  localparam logic [9:0]  PWM_LOW_STEP  = 10'(CORE_HZ / (PWM_LOW_HZ * 256));
  localparam logic [9:0]  PWM_HIGH_STEP = 10'(CORE_HZ / (PWM_HIGH_HZ * 256));
  localparam logic [7:0] ADDR_DIR_BLUE  = 8'h02;
  localparam logic [7:0] ADDR_DIR_GREEN = 8'h03;
  localparam logic [7:0] ADDR_DIR_RED   = 8'h04;
  localparam logic [7:0] ADDR_CUR_BLUE  = 8'h05;
  localparam logic [7:0] ADDR_CUR_GREEN = 8'h06;
  localparam logic [7:0] ADDR_CUR_RED   = 8'h07;
  localparam logic [7:0] ADDR_CFG       = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0c;
  localparam logic [7:0] ADDR_SOFT_RST  = 8'h0d;
  localparam logic [7:0] ADDR_DIR_WHITE = 8'h0e;
  localparam logic [7:0] ADDR_CUR_WHITE = 8'h0f;
  localparam logic [7:0] ADDR_PROG_LO   = 8'h10;
  localparam logic [7:0] ADDR_PROG_HI   = 8'h6f;
  localparam logic [7:0] ADDR_MAP       = 8'h70;
  localparam logic [7:0] SOFT_RST_CODE  = 8'hff;
  localparam logic [7:0] CUR_RESET      = 8'haf;
  localparam logic [7:0] MAP_RESET      = 8'h39;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam int CFG_FAST_BIT  = 6;
  localparam int CFG_PSAVE_BIT = 5;
  localparam logic [1:0] CLK_EXT  = 2'h0;
  localparam logic [1:0] CLK_AUTO = 2'h2;
  // Upper five bits of the bus address; arbitrary value
  localparam logic [4:0] BUS_ADDR_BASE = 5'h0c;
  localparam int PROG_BYTES = 96;
  localparam int ENG_BYTES  = 32;

  typedef enum logic [2:0] {OP_RAMP = 3'h0, OP_SET = 3'h1, OP_START = 3'h2,
                            OP_BRANCH = 3'h3, OP_END = 3'h4, OP_TRIG = 3'h5} opcode_t;
  typedef struct packed {
    opcode_t op; logic prescale; logic [5:0] stepTime; logic sign; logic [6:0] incr;
    logic [7:0] value; logic [5:0] loopCount; logic [3:0] step; logic endInt;
    logic endRst; logic [5:0] trigWait; logic [5:0] trigSend;
  } instr_t;
  typedef struct packed {
    logic [3:0] pc; logic [7:0] pwm; logic [10:0] waitCnt; logic [6:0] rampLeft;
    logic rampOn; logic [5:0] loopLeft; logic loopOn; logic halted; logic [2:0] pend;
  } eng_t;
  typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_REG = 3'h2, ST_WDATA = 3'h3,
                            ST_ACK = 3'h4, ST_RDATA = 3'h5, ST_RACK = 3'h6} bus_state_t;

  function automatic instr_t decodeInstr(input logic [15:0] w);
    instr_t d;
    d = '{op: OP_RAMP, prescale: w[14], stepTime: w[13:8], sign: w[7], incr: w[6:0],
          value: w[7:0], loopCount: w[12:7], step: w[3:0], endInt: w[12], endRst: w[11],
          trigWait: w[12:7], trigSend: w[6:1]};
    if (w == 16'h0000) d.op = OP_START;
    else if (w[15:14] == 2'h1 && w[13:8] == 6'h00) d.op = OP_SET;
    else if (w[15:13] == 3'h5) d.op = OP_BRANCH;
    else if (w[15:13] == 3'h6) d.op = OP_END;
    else if (w[15:13] == 3'h7) d.op = OP_TRIG;
    return d;
  endfunction : decodeInstr
endpackage : led_engine_pkg

/* led_pattern_engine_mapping.sv */
// Serial-bus register file, three pattern engines and channel source mapping
// Contract
// - White duty comes from map bits 7:6: 00 direct 0Eh, else engine 1-3.
// - Red duty comes from map bits 5:4: 00 direct 04h, else engine 1-3.
// - Green duty comes from map bits 3:2: 00 direct 03h, else engine 1-3.
// - Blue duty comes from map bits 1:0: 00 direct 02h, else engine 1-3.
// - Program memory sits at 10h-6Fh and clears to zero on reset.
// - Decode ramp/wait, set PWM (01, low byte) and all-zero restart.
// - Trigger holds wait flags and send flags for channels 5 to 0.
// - Config bit 6 low selects 256 Hz PWM clock.
// - Config bit 6 high selects 558 Hz PWM clock.
// - Config bits 1:0 equal 00 select external clock.
// - Codes 01 and 11 pick internal clock; 10 picks by detection.
// - Config bit 5 enables power save while outputs are inactive.
// - Current registers for blue, green, red, white at 05h-07h, 0Fh.
// - Direct white register supplies white duty under direct mapping.
// - Two select pins give one of four bus addresses.
module led_pattern_engine_mapping (
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic            ce,
  input  wire logic            sclIn,
  input  wire logic            sdaIn,
  output      logic            sdaOut,
  output      logic            sdaOe,
  input  wire logic            bus_address_select_0,
  input  wire logic            bus_address_select_1,
  input  wire logic [2:0]      engineRun,
  input  wire logic            extClockDetected,
  output      logic [3:0]      ledPwm,
  output      logic [3:0][7:0] ledCurrent,
  output      logic            pwmFastSel,
  output      logic            powerSave,
  output      logic            extClockUsed
);
  import led_engine_pkg::*;

  // ********************
  // Register file and serial slave
  // ********************
  bus_state_t      stReg, stNext, afterReg, afterNext;
  logic [3:0]      cntReg, cntNext;
  logic [7:0]      shReg, shNext, ptrReg, ptrNext, rdData;
  logic            sdaOeReg, sdaOeNext, sclPrev, sdaPrev, softRst;
  logic [7:0]      cfgReg, cfgNext, mapReg, mapNext;
  logic [3:0][7:0] dirReg, dirNext, curReg, curNext;
  logic [7:0]      memReg [PROG_BYTES];
  logic [7:0]      memNext [PROG_BYTES];
  logic [2:0]      intReg, intNext, intSet, intClr;
  logic            sclRise, sclFall, startCond, stopCond, addrHit;
  eng_t [2:0]      engReg, engNext;
  instr_t [2:0]    curInstr;

  assign sclRise   = sclIn & ~sclPrev;
  assign sclFall   = ~sclIn & sclPrev;
  assign startCond = sclIn & sclPrev & sdaPrev & ~sdaIn;
  assign stopCond  = sclIn & sclPrev & ~sdaPrev & sdaIn;
  assign addrHit   = shReg[7:1] == {BUS_ADDR_BASE, bus_address_select_1, bus_address_select_0};

  always_comb begin
    case (ptrReg)
      ADDR_DIR_BLUE:  rdData = dirReg[0];
      ADDR_DIR_GREEN: rdData = dirReg[1];
      ADDR_DIR_RED:   rdData = dirReg[2];
      ADDR_DIR_WHITE: rdData = dirReg[3];
      ADDR_CUR_BLUE:  rdData = curReg[0];
      ADDR_CUR_GREEN: rdData = curReg[1];
      ADDR_CUR_RED:   rdData = curReg[2];
      ADDR_CUR_WHITE: rdData = curReg[3];
      ADDR_CFG:       rdData = cfgReg;
      ADDR_MAP:       rdData = mapReg;
      ADDR_STATUS:    rdData = {4'h0, extClockUsed, intReg[0], intReg[1], intReg[2]};
      default: begin
        if (ptrReg >= ADDR_PROG_LO && ptrReg <= ADDR_PROG_HI) begin
          rdData = memReg[7'(ptrReg - ADDR_PROG_LO)];
        end else begin
          rdData = 8'h00;
        end
      end
    endcase
  end

  always_comb begin
    stNext = stReg; afterNext = afterReg; cntNext = cntReg; shNext = shReg;
    ptrNext = ptrReg; sdaOeNext = sdaOeReg; cfgNext = cfgReg; mapNext = mapReg;
    dirNext = dirReg; curNext = curReg; memNext = memReg; softRst = 1'b0; intClr = 3'h0;
    if (startCond) begin
      stNext = ST_ADDR; cntNext = 4'h0; sdaOeNext = 1'b0;
    end else if (stopCond) begin
      stNext = ST_IDLE; sdaOeNext = 1'b0;
    end else begin
      case (stReg)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (sclRise) begin
            shNext = {shReg[6:0], sdaIn}; cntNext = cntReg + 4'h1;
          end else if (sclFall && cntReg == 4'h8) begin
            stNext = ST_ACK; cntNext = 4'h0; sdaOeNext = 1'b1;
            if (stReg == ST_ADDR) begin
              afterNext = shReg[0] ? ST_RDATA : ST_REG;
              if (!addrHit) begin
                stNext = ST_IDLE; sdaOeNext = 1'b0;
              end
            end else if (stReg == ST_REG) begin
              ptrNext = shReg; afterNext = ST_WDATA;
            end else begin
              ptrNext = ptrReg + 8'h01; afterNext = ST_WDATA;
              case (ptrReg)
                ADDR_DIR_BLUE:  dirNext[0] = shReg;
                ADDR_DIR_GREEN: dirNext[1] = shReg;
                ADDR_DIR_RED:   dirNext[2] = shReg;
                ADDR_DIR_WHITE: dirNext[3] = shReg;
                ADDR_CUR_BLUE:  curNext[0] = shReg;
                ADDR_CUR_GREEN: curNext[1] = shReg;
                ADDR_CUR_RED:   curNext[2] = shReg;
                ADDR_CUR_WHITE: curNext[3] = shReg;
                ADDR_CFG:       cfgNext = shReg;
                ADDR_MAP:       mapNext = shReg;
                ADDR_SOFT_RST:  softRst = shReg == SOFT_RST_CODE;
                default: begin
                  if (ptrReg >= ADDR_PROG_LO && ptrReg <= ADDR_PROG_HI) begin
                    memNext[7'(ptrReg - ADDR_PROG_LO)] = shReg;
                  end
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            stNext = afterReg; sdaOeNext = 1'b0;
            if (afterReg == ST_RDATA) begin
              // Status flags clear as the byte is taken for shifting out
              if (ptrReg == ADDR_STATUS) intClr = 3'h7;
              sdaOeNext = ~rdData[7]; shNext = {rdData[6:0], 1'b0};
              cntNext = 4'h1; ptrNext = ptrReg + 8'h01;
            end
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            if (cntReg == 4'h8) begin
              sdaOeNext = 1'b0; stNext = ST_RACK;
            end else begin
              sdaOeNext = ~shReg[7]; shNext = {shReg[6:0], 1'b0}; cntNext = cntReg + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            stNext = sdaIn ? ST_IDLE : ST_ACK; afterNext = ST_RDATA;
          end
        end
        default: stNext = ST_IDLE;
      endcase
    end
    intNext = (intReg & ~intClr) | intSet;
    if (softRst) begin
      cfgNext = CFG_RESET; mapNext = MAP_RESET; dirNext = '0; intNext = 3'h0;
      curNext = {4{CUR_RESET}};
      for (int i = 0; i < PROG_BYTES; i++) memNext[i] = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stReg <= ST_IDLE; afterReg <= ST_IDLE; cntReg <= 4'h0; shReg <= 8'h00;
      ptrReg <= 8'h00; sdaOeReg <= 1'b0; sclPrev <= 1'b1; sdaPrev <= 1'b1;
      cfgReg <= CFG_RESET; mapReg <= MAP_RESET; dirReg <= '0; intReg <= 3'h0;
      curReg <= {4{CUR_RESET}};
      for (int i = 0; i < PROG_BYTES; i++) memReg[i] <= 8'h00;
    end else if (ce) begin
      stReg <= stNext; afterReg <= afterNext; cntReg <= cntNext; shReg <= shNext;
      ptrReg <= ptrNext; sdaOeReg <= sdaOeNext; sclPrev <= sclIn; sdaPrev <= sdaIn;
      cfgReg <= cfgNext; mapReg <= mapNext; dirReg <= dirNext; intReg <= intNext;
      curReg <= curNext; memReg <= memNext;
    end
  end

  assign sdaOe      = sdaOeReg;
  assign sdaOut     = 1'b0;
  assign ledCurrent = curReg;
  assign pwmFastSel = cfgReg[CFG_FAST_BIT];

  // ********************
  // Pattern engines
  // ********************
  logic [10:0] tickReg, tickNext;
  logic        engTick;
  logic [5:0]  loopLeft;

  assign engTick = tickReg == TICK_CYCLES - 11'h001;

  always_comb begin
    for (int e = 0; e < 3; e++) begin
      curInstr[e] = decodeInstr({memReg[7'(e * ENG_BYTES) + {2'h0, engReg[e].pc, 1'b0}],
                                 memReg[7'(e * ENG_BYTES) + {2'h0, engReg[e].pc, 1'b1}]});
    end
  end

  always_comb begin
    engNext = engReg; intSet = 3'h0; loopLeft = 6'h00;
    tickNext = engTick ? 11'h000 : tickReg + 11'h001;
    for (int e = 0; e < 3; e++) begin
      if (!engineRun[e]) begin
        engNext[e].halted = 1'b0;
      end else if (engTick && !engReg[e].halted) begin
        if (engReg[e].waitCnt != 11'h000) begin
          engNext[e].waitCnt = engReg[e].waitCnt - 11'h001;
        end else begin
          case (curInstr[e].op)
            OP_RAMP: begin
              // Prescale stretches each step thirty-two fold
              engNext[e].waitCnt = curInstr[e].prescale ? {curInstr[e].stepTime, 5'h00}
                                                        : {5'h00, curInstr[e].stepTime};
              if (!engReg[e].rampOn) begin
                engNext[e].rampOn = 1'b1; engNext[e].rampLeft = curInstr[e].incr;
              end else if (engReg[e].rampLeft != 7'h00) begin
                engNext[e].rampLeft = engReg[e].rampLeft - 7'h01;
                if (curInstr[e].sign && engReg[e].pwm != 8'h00) begin
                  engNext[e].pwm = engReg[e].pwm - 8'h01;
                end else if (!curInstr[e].sign && engReg[e].pwm != 8'hff) begin
                  engNext[e].pwm = engReg[e].pwm + 8'h01;
                end
              end else begin
                engNext[e].rampOn = 1'b0; engNext[e].waitCnt = 11'h000;
                engNext[e].pc = engReg[e].pc + 4'h1;
              end
            end
            OP_SET: begin
              engNext[e].pwm = curInstr[e].value; engNext[e].pc = engReg[e].pc + 4'h1;
            end
            OP_START: engNext[e].pc = 4'h0;
            OP_BRANCH: begin
              loopLeft = engReg[e].loopOn ? engReg[e].loopLeft : curInstr[e].loopCount;
              // Zero loop count repeats forever
              if (curInstr[e].loopCount == 6'h00 || loopLeft != 6'h00) begin
                engNext[e].pc = curInstr[e].step; engNext[e].loopOn = 1'b1;
                engNext[e].loopLeft = loopLeft - 6'h01;
              end else begin
                engNext[e].loopOn = 1'b0; engNext[e].pc = engReg[e].pc + 4'h1;
              end
            end
            OP_END: begin
              engNext[e].halted = 1'b1; intSet[e] = curInstr[e].endInt;
              if (curInstr[e].endRst) engNext[e].pc = 4'h0;
            end
            OP_TRIG: begin
              // Only channels 0-2 exist here; they stand for the three engines
              if ((curInstr[e].trigWait[2:0] & ~engReg[e].pend) == 3'h0) begin
                engNext[e].pend = engNext[e].pend & ~curInstr[e].trigWait[2:0];
                for (int j = 0; j < 3; j++) begin
                  if (curInstr[e].trigSend[j]) engNext[j].pend[e] = 1'b1;
                end
                engNext[e].pc = engReg[e].pc + 4'h1;
              end
            end
            default: engNext[e].pc = engReg[e].pc + 4'h1;
          endcase
        end
      end
    end
    if (softRst) engNext = '0;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      engReg <= '0; tickReg <= 11'h000;
    end else if (ce) begin
      engReg <= engNext; tickReg <= tickNext;
    end
  end

  // ********************
  // Channel mapping and PWM outputs
  // ********************
  logic [3:0][7:0] dutyReg, dutyNext;
  logic [9:0]      preReg, preNext;
  logic [7:0]      phaseReg, phaseNext;
  logic [3:0]      pinNext;
  logic            psNext, extNext, preWrap;
  logic [1:0]      sel;

  // Compare as at-or-above: a rate switch may leave the count past the new wrap point
  assign preWrap = preReg >= (cfgReg[CFG_FAST_BIT] ? PWM_HIGH_STEP : PWM_LOW_STEP) - 10'h001;

  always_comb begin
    sel = 2'h0;
    for (int i = 0; i < 4; i++) begin
      sel = mapReg[i * 2 +: 2];
      dutyNext[i] = sel == 2'h0 ? dirReg[i] : engReg[sel - 2'h1].pwm;
      pinNext[i] = phaseReg < dutyReg[i];
    end
    preNext = preWrap ? 10'h000 : preReg + 10'h001;
    phaseNext = preWrap ? phaseReg + 8'h01 : phaseReg;
    psNext = cfgReg[CFG_PSAVE_BIT] && dutyReg == '0;
    extNext = cfgReg[1:0] == CLK_EXT || (cfgReg[1:0] == CLK_AUTO && extClockDetected);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dutyReg <= '0; preReg <= 10'h000; phaseReg <= 8'h00; ledPwm <= 4'h0;
      powerSave <= 1'b0; extClockUsed <= 1'b0;
    end else if (ce) begin
      dutyReg <= dutyNext; preReg <= preNext; phaseReg <= phaseNext; ledPwm <= pinNext;
      powerSave <= psNext; extClockUsed <= extNext;
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence eng0Turn;
    ce && engTick && engineRun[0] && !engReg[0].halted && engReg[0].waitCnt == 11'h000
    && !softRst;
  endsequence

  chk_white_direct: assert property (ce && mapReg[7:6] == 2'h0 |=> dutyReg[3] == $past(dirReg[3])) else $error("white duty not direct");
  chk_red_engine: assert property (ce && mapReg[5:4] == 2'h2 |=> dutyReg[2] == $past(engReg[1].pwm)) else $error("red duty not engine 2");
  chk_green_engine: assert property (ce && mapReg[3:2] == 2'h1 |=> dutyReg[1] == $past(engReg[0].pwm)) else $error("green duty not engine 1");
  chk_blue_engine: assert property (ce && mapReg[1:0] == 2'h3 |=> dutyReg[0] == $past(engReg[2].pwm)) else $error("blue duty not engine 3");
  chk_prog_clear: assert property ($fell(reset) |-> memReg[0] == 8'h00 && memReg[95] == 8'h00) else $error("memory not cleared");
  chk_set_pwm: assert property (eng0Turn ##0 curInstr[0].op == OP_SET |=> engReg[0].pwm == $past(curInstr[0].value) && engReg[0].pc == 4'($past(engReg[0].pc) + 4'h1)) else $error("set pwm wrong");
  // First pass of a counted loop and every pass of an endless one jump back
  chk_branch_jump: assert property (eng0Turn ##0 curInstr[0].op == OP_BRANCH &&
    (curInstr[0].loopCount == 6'h00 || !engReg[0].loopOn)
    |=> engReg[0].pc == $past(curInstr[0].step)) else $error("branch missed");
  chk_end_halt: assert property (eng0Turn ##0 curInstr[0].op == OP_END && curInstr[0].endInt |=> engReg[0].halted && intReg[0]) else $error("end did not halt");
  chk_pwm_rate: assert property (ce && preWrap |=> preReg == 10'h000 && phaseReg == 8'($past(phaseReg) + 8'h01)) else $error("pwm step wrong");
  chk_clk_source: assert property (ce |=> extClockUsed == ($past(cfgReg[1:0]) == CLK_EXT || ($past(cfgReg[1:0]) == CLK_AUTO && $past(extClockDetected)))) else $error("clock source wrong");
  chk_psave_off: assert property (ce && !cfgReg[CFG_PSAVE_BIT] |=> !powerSave) else $error("power save while disabled");
  chk_addr_ack: assert property (ce && stReg == ST_ADDR && sclFall && cntReg == 4'h8 && addrHit && !startCond && !stopCond |=> sdaOe ##1 stReg == ST_ACK || sclFall) else $error("address not acked");
endmodule : led_pattern_engine_mapping

/* led_pattern_engine_mapping_tb_top.sv */
// Self-checking bench with a register model of the LED device
module led_pattern_engine_mapping_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import led_engine_pkg::*;
  logic            core_clk = 1'b0;
  logic            reset = 1'b1;
  logic            sel0, sel1, extDet;
  logic [2:0]      run = 3'h0;
  logic            scl, sda, sdaOut, sdaOe, pwmFastSel, powerSave, extClockUsed;
  logic [3:0]      ledPwm;
  logic [3:0][7:0] ledCurrent;
  logic [6:0]      dev;
  logic [7:0]      v;
  int              errCount, nChecks, cyc, model[256];
  int              seed = 32'hb2e1;
  assign dev = {BUS_ADDR_BASE, sel1, sel0};
  always #12.5 core_clk = ~core_clk;
  i2c_host_model host (.clk(core_clk), .sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl), .sda(sda));
  led_pattern_engine_mapping dut (.core_clk(core_clk), .reset(reset), .ce(1'b1),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .bus_address_select_0(sel0),
    .bus_address_select_1(sel1), .engineRun(run), .extClockDetected(extDet),
    .ledPwm(ledPwm), .ledCurrent(ledCurrent), .pwmFastSel(pwmFastSel),
    .powerSave(powerSave), .extClockUsed(extClockUsed));
  // ****************************************
  // Checking helpers
  // ****************************************
  function automatic bit mapped(input int a);
    return (a >= 2 && a <= 8) || (a >= 14 && a <= 112);
  endfunction : mapped
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input int q[$]);
    logic [7:0] r;
    logic       ack;
    host.start();
    host.xfer({dev, 1'b0}, 1'b1, r, ack);
    check("addr ack", 8'h00, {7'h0, ack});
    host.xfer(a, 1'b1, r, ack);
    foreach (q[i]) begin
      host.xfer(8'(q[i]), 1'b1, r, ack);
      if (mapped(a + i)) model[8'(a + i)] = q[i] & 255;
    end
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    logic ack;
    host.start();
    host.xfer({dev, 1'b0}, 1'b1, r, ack);
    host.xfer(a, 1'b1, r, ack);
    host.start();
    host.xfer({dev, 1'b1}, 1'b1, r, ack);
    host.xfer(8'hff, 1'b1, r, ack);
    host.stop();
  endtask : rd
  task automatic rdChk(input logic [7:0] a);
    logic [7:0] r;
    rd(a, r);
    check($sformatf("reg %h", a), mapped(a) ? 8'(model[a]) : 8'h00, r);
  endtask : rdChk
  // Window beyond one 610-cycle phase: full duty is never low throughout
  task automatic pwmChk(input logic [3:0] exp);
    int n[4];
    n = '{default: 0};
    repeat (700) begin
      @(posedge core_clk);
      foreach (n[c]) n[c] += int'(ledPwm[c] === 1'b1);
    end
    foreach (n[c]) check($sformatf("ledPwm %0d", c), {7'h0, exp[c]}, {7'h0, n[c] > 0});
  endtask : pwmChk
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tallyAndFinish
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errCount++;
      tallyAndFinish();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] r;
    logic       ack;
    {sel1, sel0} <= 2'($random(seed));
    extDet <= 1'b0;
    foreach (model[i]) model[i] = 0;
    model[5] = 'haf;
    model[6] = 'haf;
    model[7] = 'haf;
    model[15] = 'haf;
    model[112] = 'h39;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (model[a]) if (a inside {5, 6, 7, 8, 15, 16, 111, 112, 128}) rdChk(8'(a));
    $display("test reset values done");
    host.start();
    host.xfer({dev[6:2], ~dev[1:0], 1'b0}, 1'b1, r, ack);
    host.stop();
    check("foreign addr", 8'h01, {7'h0, ack});
    // Host sets up the four current registers before any program runs
    wr(ADDR_CUR_BLUE, '{$random(seed), $random(seed), $random(seed)});
    wr(ADDR_CUR_WHITE, '{$random(seed)});
    foreach (ledCurrent[c]) check("current", 8'(model[c < 3 ? 5 + c : 15]), ledCurrent[c]);
    rdChk(ADDR_CUR_RED);
    wr(8'h80, '{8'h5a});
    rdChk(8'h80);
    $display("test currents done");
    for (int k = 0; k < 8; k++) begin
      extDet <= k[2];
      wr(ADDR_CFG, '{int'({1'b0, k[0], k[1], 3'h0, k[1:0]})});
      repeat (5) @(posedge core_clk);
      check("fast", {7'h0, k[0]}, {7'h0, pwmFastSel});
      check("ext", {7'h0, k[1:0] == 0 || (k[1:0] == 2 && k[2])}, {7'h0, extClockUsed});
      check("psave", {7'h0, k[1]}, {7'h0, powerSave});
    end
    wr(ADDR_CFG, '{0});
    rdChk(ADDR_CFG);
    $display("test config done");
    wr(ADDR_MAP, '{0});
    wr(ADDR_DIR_BLUE, '{255, 0, 255});
    wr(ADDR_DIR_WHITE, '{0});
    pwmChk(4'b0101);
    wr(ADDR_DIR_BLUE, '{0, 255, 0});
    wr(ADDR_DIR_WHITE, '{255});
    pwmChk(4'b1010);
    $display("test direct map done");
    // Engine outputs are the inverse of the direct values, so a dead map shows
    // Engine 2 sets its duty only after engine 1 loops once and sends a trigger
    wr(ADDR_PROG_LO, '{'h40, 'h00, 'ha0, 'h80, 'he0, 'h04, 'hd0, 'h00});
    wr(8'h30, '{'he0, 'h80, 'h40, 'hff, 'hd0, 'h00});
    wr(8'h50, '{'h40, 'hff, 'hd0, 'h00});
    rdChk(8'h51);
    wr(ADDR_MAP, '{'h67});
    run <= 3'h7;
    repeat (12000) @(posedge core_clk);
    pwmChk(4'b0101);
    rd(ADDR_STATUS, v);
    check("status", 8'h0f, v);
    rd(ADDR_STATUS, v);
    check("status cleared", 8'h08, v);
    $display("test engines done");
    tallyAndFinish();
  end
endmodule : led_pattern_engine_mapping_tb_top
